//--- inc/fcpwm_consts.vh
// Purpose: shared constants for the four-channel pulse width generator
// Assumes: 125 MHz reference clock
// Notes: duty in hundredths of a percent, frequency in hertz
`ifndef FCPWM_CONSTS_VH
`define FCPWM_CONSTS_VH

// ----------------------------------------------------------------
// clock and ranges
// ----------------------------------------------------------------
`define FCPWM_CLK_HZ 32'd125000000
`define FCPWM_FREQ_MIN_HZ 17'd50
`define FCPWM_FREQ_MAX_HZ 17'd50000
`define FCPWM_DUTY_FULL 14'd10000
`define FCPWM_DUTY_STEPS_PER_PCT 7'd100

// ----------------------------------------------------------------
// channel to output slot mapping (slot 0 = output five)
// ----------------------------------------------------------------
`define FCPWM_SLOT_OUT5 2'd2
`define FCPWM_SLOT_OUT6 2'd3
`define FCPWM_SLOT_OUT7 2'd0
`define FCPWM_SLOT_OUT8 2'd1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FCPWM_RST_PERIOD 22'h000000
`define FCPWM_RST_HIGH 22'h000000

`endif

//--- core/fcpwm_divider.v
// Purpose: sequential divider for period and on-time computation
// Assumes: one request at a time; start ignored while busy
// Notes: restoring division, one quotient bit per clock
`timescale 1ns/1ps

module fcpwm_divider #(
    parameter NW = 40, // numerator width
    parameter DW = 17  // denominator width
) (
    // clock and reset
    input wire clk,
    input wire rstSync_n,
    // request
    input wire start,
    input wire [NW-1:0] numer,
    input wire [DW-1:0] denom,
    // answer
    output reg busy_q,
    output reg done_q,
    output reg [NW-1:0] quot_q
);

    reg [DW:0] rem_q; // partial remainder, one guard bit
    reg [NW-1:0] num_q; // numerator being shifted out
    reg [DW-1:0] den_q; // held denominator
    reg [6:0] cnt_q; // bits still to produce
    wire [DW:0] trial; // remainder with next bit shifted in
    wire fits; // trial subtraction does not go negative

    assign trial = {rem_q[DW-1:0], num_q[NW-1]};
    assign fits = (trial >= {1'b0, den_q});

    // ------------------------------------------------------------
    // one quotient bit per cycle
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            quot_q <= {NW{1'b0}};
            rem_q <= {(DW+1){1'b0}};
            num_q <= {NW{1'b0}};
            den_q <= {DW{1'b0}};
            cnt_q <= 7'h00;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                // accept a new request only while idle
                if (start) begin
                    busy_q <= 1'b1;
                    num_q <= numer;
                    den_q <= denom;
                    rem_q <= {(DW+1){1'b0}};
                    cnt_q <= NW[6:0];
                end
            end else begin
                num_q <= {num_q[NW-2:0], 1'b0};
                quot_q <= {quot_q[NW-2:0], fits};
                rem_q <= fits ? (trial - {1'b0, den_q}) : trial;
                cnt_q <= cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule // fcpwm_divider

//--- core/fcpwm_top.v
// Purpose: four-channel pulse width generator with per-channel setup
// Assumes: ref_clk at 125 MHz; command port synchronous to ref_clk
// Notes: period = round(clk/freq) cycles, so error stays far inside
//        spec; on-time = period*duty/10000; new settings wait for
//        the current period to end
`timescale 1ns/1ps
`include "fcpwm_consts.vh"

// Behaviour
// - four channels on outputs five to eight
// - output on then off, repeating each period
// - any frequency from 50 Hz to 50 kHz
// - frequency error below specified limits
// - one command: channel, duty, frequency
// - duty 0 to 100 percent, fine resolution
// - duty word may come from program data
module fcpwm_top #(
    parameter PW = 22 // period counter width; 2500000 cycles at 50 Hz
) (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // set_pulse_width_command port
    input wire cmdValid,
    input wire [1:0] cmdChannel,
    input wire [15:0] cmdDuty,
    input wire [16:0] cmdFreq,
    // command status
    output reg cmdReady_q,
    output reg cmdError_q,
    // digital outputs five to eight, bit 0 = output five
    output reg [3:0] pwmOut_q
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    reg rstMeta_q; // first stage, read only by the second
    reg rstSync_q; // released reset for the rest of the design

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // ------------------------------------------------------------
    // per-channel storage
    // ------------------------------------------------------------
    reg [PW-1:0] perAct_q [0:3]; // period in use
    reg [PW-1:0] highAct_q [0:3]; // on-time in use
    reg [PW-1:0] perNew_q [0:3]; // pending period
    reg [PW-1:0] highNew_q [0:3]; // pending on-time
    reg [3:0] pend_q; // pending settings flag
    reg [PW-1:0] cnt_q [0:3]; // position in period
    reg [3:0] chanOut_q; // raw channel levels

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_PER = 2'd1;
    localparam ST_HIGH = 2'd2;

    reg [1:0] state_q; // sequencer state
    reg [1:0] chSel_q; // channel being set up
    reg [13:0] duty_q; // accepted duty word
    reg [PW-1:0] per_q; // computed period
    reg divStart_q; // divider start pulse
    reg [39:0] divNum_q; // divider numerator
    reg [16:0] divDen_q; // divider denominator
    wire divDone; // divider result valid
    wire [39:0] divQuot; // divider result

    fcpwm_divider #(.NW(40), .DW(17)) uDiv (
        .clk(ref_clk),
        .rstSync_n(rstSync_q),
        .start(divStart_q),
        .numer(divNum_q),
        .denom(divDen_q),
        .busy_q(),
        .done_q(divDone),
        .quot_q(divQuot)
    );

    // rounds the clock count to the nearest whole cycle
    function [39:0] halfUp;
        input [16:0] f;
        begin
            halfUp = {8'h00, `FCPWM_CLK_HZ} + {24'h000000, f[16:1]};
        end
    endfunction

    integer i; // loop index, command sequencer only
    integer k; // loop index, period counters only

    // ------------------------------------------------------------
    // accept commands and compute settings
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            state_q <= ST_IDLE;
            chSel_q <= 2'd0;
            duty_q <= 14'h0000;
            per_q <= `FCPWM_RST_PERIOD;
            divStart_q <= 1'b0;
            divNum_q <= 40'h0000000000;
            divDen_q <= 17'h00000;
            cmdReady_q <= 1'b0;
            cmdError_q <= 1'b0;
            pend_q <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                perNew_q[i] <= `FCPWM_RST_PERIOD;
                highNew_q[i] <= `FCPWM_RST_HIGH;
            end
        end else begin
            divStart_q <= 1'b0;
            // pending flags drop when the channel wraps
            for (i = 0; i < 4; i = i + 1) begin
                if (cnt_q[i] + 1'b1 >= perAct_q[i]) begin
                    pend_q[i] <= 1'b0;
                end
            end
            case (state_q)
                ST_IDLE: begin
                    cmdReady_q <= 1'b1;
                    if (cmdValid && cmdReady_q) begin
                        cmdReady_q <= 1'b0;
                        if (cmdFreq < `FCPWM_FREQ_MIN_HZ ||
                            cmdFreq > `FCPWM_FREQ_MAX_HZ) begin
                            cmdError_q <= 1'b1;
                        end else begin
                            cmdError_q <= 1'b0;
                            chSel_q <= cmdChannel;
                            duty_q <= (cmdDuty > {2'b00, `FCPWM_DUTY_FULL})
                                ? `FCPWM_DUTY_FULL : cmdDuty[13:0];
                            divNum_q <= halfUp(cmdFreq);
                            divDen_q <= cmdFreq;
                            divStart_q <= 1'b1;
                            state_q <= ST_PER;
                        end
                    end
                end
                ST_PER: begin
                    if (divDone) begin
                        per_q <= divQuot[PW-1:0];
                        divNum_q <= divQuot[25:0] * duty_q;
                        divDen_q <= {3'b000, `FCPWM_DUTY_FULL};
                        divStart_q <= 1'b1;
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (divDone) begin
                        perNew_q[chSel_q] <= per_q;
                        highNew_q[chSel_q] <= divQuot[PW-1:0];
                        pend_q[chSel_q] <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // period counters and waveform
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            chanOut_q <= 4'h0;
            for (k = 0; k < 4; k = k + 1) begin
                cnt_q[k] <= {PW{1'b0}};
                perAct_q[k] <= `FCPWM_RST_PERIOD;
                highAct_q[k] <= `FCPWM_RST_HIGH;
            end
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (cnt_q[k] + 1'b1 >= perAct_q[k]) begin
                    cnt_q[k] <= {PW{1'b0}};
                    if (pend_q[k]) begin
                        perAct_q[k] <= perNew_q[k];
                        highAct_q[k] <= highNew_q[k];
                        chanOut_q[k] <= (highNew_q[k] != {PW{1'b0}});
                    end else begin
                        chanOut_q[k] <= (highAct_q[k] != {PW{1'b0}});
                    end
                end else begin
                    cnt_q[k] <= cnt_q[k] + 1'b1;
                    // on for the first part, then off
                    chanOut_q[k] <= (cnt_q[k] + 1'b1 < highAct_q[k]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output mapping
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            pwmOut_q <= 4'h0;
        end else begin
            // channel two on five, one on eight
            pwmOut_q[0] <= chanOut_q[`FCPWM_SLOT_OUT5];
            pwmOut_q[1] <= chanOut_q[`FCPWM_SLOT_OUT6];
            pwmOut_q[2] <= chanOut_q[`FCPWM_SLOT_OUT7];
            pwmOut_q[3] <= chanOut_q[`FCPWM_SLOT_OUT8];
        end
    end

endmodule // fcpwm_top

//--- tb/fcpwm_monitor.sv
// Purpose: port checker for the pulse generator
// Assumes: bound to fcpwm_top by the testbench
// Notes: 50 kHz top rate spaces rises 2500 cycles
`timescale 1ns/1ps
module fcpwm_monitor (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // command side
    input wire cmdValid,
    input wire [16:0] cmdFreq,
    input wire cmdReady_q,
    input wire cmdError_q,
    // outputs five to eight
    input wire [3:0] pwmOut_q
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    wire take = cmdValid && cmdReady_q; // request accepted
    wire bad = (cmdFreq < 17'd50) || (cmdFreq > 17'd50000); // refused
    default clocking monClk @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_wake_ready: assert property ($rose(rstn) |-> ##[1:4] cmdReady_q)
        else $error("ready late after reset");
    a_quiet_reset: assert property ($rose(rstn) |-> (pwmOut_q == 4'h0) [*3])
        else $error("output active after reset");
    a_err_set: assert property (take && bad |=> cmdError_q ##1 cmdReady_q)
        else $error("bad rate not refused");
    a_ready_back: assert property (take && !bad |=> !cmdReady_q ##[40:200] cmdReady_q)
        else $error("command never completed");
    a_err_clear: assert property (take && !bad |-> ##[1:200] !cmdError_q)
        else $error("error kept after good command");
    a_err_holds: assert property (cmdError_q && cmdReady_q && !cmdValid |=> cmdError_q)
        else $error("error dropped while idle");
    a_ready_stays: assert property (cmdReady_q && !cmdValid |=> cmdReady_q)
        else $error("ready dropped with no request");
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gSlot
            reg [21:0] gap_q; // cycles since last rise, saturating
            reg seen_q; // a rise was seen since reset
            // a rise restarts the count
            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    gap_q <= 22'h000000;
                    seen_q <= 1'b0;
                end else if ($rose(pwmOut_q[g])) begin
                    gap_q <= 22'h000000;
                    seen_q <= 1'b1;
                end else if (gap_q != 22'h3FFFFF) begin
                    gap_q <= gap_q + 22'h000001;
                end
            end
            a_rise_spacing: assert property ($rose(pwmOut_q[g]) && seen_q |-> gap_q >= 22'd2499)
                else $error("output period too short");
        end
    endgenerate
endmodule // fcpwm_monitor

//--- tb/fcpwm_load.sv
// Purpose: load model timing each output period
// Assumes: outputs high means driver on
// Notes: reports at each rise after the first
`timescale 1ns/1ps
module fcpwm_load (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // outputs five to eight
    input wire [3:0] pwmOut_q,
    // one report per slot, 22 bits each
    output reg [3:0] measValid,
    output reg [87:0] measPeriod,
    output reg [87:0] measHigh
);
    reg [3:0] last; // previous level
    reg [3:0] armed; // a rise was seen
    reg [21:0] per [0:3]; // cycles since rise
    reg [21:0] hi [0:3]; // high cycles since rise
    integer i;
    always @(posedge ref_clk) begin
        for (i = 0; i < 4; i = i + 1) begin
            measValid[i] <= 1'b0;
            if (!rstn) begin
                armed[i] <= 1'b0;
            end else if (pwmOut_q[i] && !last[i]) begin
                measValid[i] <= armed[i];
                measPeriod[i*22 +: 22] <= per[i];
                measHigh[i*22 +: 22] <= hi[i];
                armed[i] <= 1'b1;
                per[i] <= 22'h000001;
                hi[i] <= 22'h000001;
            end else begin
                per[i] <= per[i] + 22'h000001;
                hi[i] <= hi[i] + {21'h000000, pwmOut_q[i]};
            end
            last[i] <= rstn ? pwmOut_q[i] : 1'b0;
        end
    end
endmodule // fcpwm_load

//--- tb/testbench.sv
// Purpose: self-checking bench for fcpwm_top
// Assumes: inputs change on falling edges
// Notes: fast rates only, to keep the run short
`timescale 1ns/1ps
module testbench;
    reg ref_clk = 1'b0;
    reg rstn = 1'b0;
    reg cmdValid = 1'b0;
    reg [1:0] cmdChannel = 2'h0;
    reg [15:0] cmdDuty = 16'h0000;
    reg [16:0] cmdFreq = 17'h00000;
    wire cmdReady_q;
    wire cmdError_q;
    wire [3:0] pwmOut_q;
    wire [3:0] measValid;
    wire [87:0] measPeriod;
    wire [87:0] measHigh;
    integer bad_count = 0;
    integer cmp_count = 0;
    integer seed, i, j, k, n;
    reg [16:0] fq [0:3]; // rate per channel
    reg [15:0] dt [0:3]; // duty per channel
    reg [45:0] q [$]; // notes: slot, period, high
    reg [45:0] h; // note under test
    fcpwm_top i_fcpwm_top (.ref_clk(ref_clk), .rstn(rstn),
        .cmdValid(cmdValid), .cmdChannel(cmdChannel), .cmdDuty(cmdDuty),
        .cmdFreq(cmdFreq), .cmdReady_q(cmdReady_q),
        .cmdError_q(cmdError_q), .pwmOut_q(pwmOut_q));
    fcpwm_load i_fcpwm_load (.ref_clk(ref_clk), .rstn(rstn),
        .pwmOut_q(pwmOut_q), .measValid(measValid),
        .measPeriod(measPeriod), .measHigh(measHigh));
    initial forever #4 ref_clk = ~ref_clk;
    task check(input [21:0] e, input [21:0] a);
        begin
            cmp_count = cmp_count + 1;
            if (a !== e) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: want %h got %h", $time, e, a);
            end
        end
    endtask
    task wready;
        begin
            for (n = 0; n < 400 && cmdReady_q !== 1'b1; n = n + 1)
                @(negedge ref_clk);
            check(22'h000001, {21'h000000, cmdReady_q});
        end
    endtask
    task send(input [1:0] c, input [15:0] d, input [16:0] f);
        begin
            wready;
            cmdChannel = c;
            cmdDuty = d;
            cmdFreq = f;
            cmdValid = 1'b1;
            @(negedge ref_clk);
            cmdValid = 1'b0;
            @(negedge ref_clk);
        end
    endtask
    // expected period rounds, high time truncates
    task note(input [1:0] c, input [15:0] d, input [16:0] f);
        reg [63:0] p, t;
        begin
            p = (64'd125000000 + f / 2) / f;
            t = p * (d > 16'd10000 ? 16'd10000 : d) / 64'd10000;
            q.push_back({c ^ 2'h2, p[21:0], t[21:0]});
        end
    endtask
    task drain;
        begin
            for (n = 0; n < 20000 && q.size() > 0; n = n + 1)
                @(negedge ref_clk);
            check(22'h000000, 22'(q.size()));
            q.delete();
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d, mismatched %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // compare each report from the oldest note's slot with that note
    always @(posedge ref_clk) begin
        if (q.size() > 0 && measValid[q[0][45:44]] === 1'b1) begin
            h = q.pop_front();
            check(h[43:22], measPeriod[h[45:44]*22 +: 22]);
            check(h[21:0], measHigh[h[45:44]*22 +: 22]);
        end
    end
    initial begin
        seed = $urandom(68774);
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            fq[i] = i == 3 ? 17'd50000 : 17'd35000 + 17'($urandom % 15001);
            dt[i] = i == 3 ? 16'd9000 : 16'd4 + 16'($urandom % 9996);
            send(i[1:0], dt[i], fq[i]);
            wready;
            note(i[1:0], dt[i], fq[i]);
            note(i[1:0], dt[i], fq[i]);
            drain;
        end
        $display("test channels done");
        send(2'h0, 16'd5000, 17'd49);
        check(22'h000001, {21'h000000, cmdError_q});
        send(2'h0, 16'd5000, 17'd50001);
        check(22'h000001, {21'h000000, cmdError_q});
        for (j = 0; j < 2; j = j + 1) begin
            send(2'h1, j ? 16'd0 : 16'd12000, 17'd40000);
            wready;
            repeat (6500) @(negedge ref_clk);
            k = 0;
            for (i = 0; i < 3200; i = i + 1) begin
                @(negedge ref_clk);
                k = k + (pwmOut_q[3] !== (j == 0));
            end
            check(22'h000000, k[21:0]);
        end
        check(22'h000000, {21'h000000, cmdError_q});
        $display("test refusal and limits done");
        @(posedge pwmOut_q[0]);
        @(negedge ref_clk);
        send(2'h2, 16'd2500, 17'd31250);
        wready;
        note(2'h2, dt[2], fq[2]);
        note(2'h2, 16'd2500, 17'd31250);
        drain;
        $display("test live change done");
        complete_run;
    end
    initial begin
        repeat (95000) @(posedge ref_clk);
        bad_count = bad_count + 1;
        complete_run;
    end
endmodule // testbench
bind fcpwm_top fcpwm_monitor i_fcpwm_monitor (.ref_clk(ref_clk),
    .rstn(rstn), .cmdValid(cmdValid), .cmdFreq(cmdFreq),
    .cmdReady_q(cmdReady_q), .cmdError_q(cmdError_q),
    .pwmOut_q(pwmOut_q));
